// ===== include/ecl_map.vh
// constants for the eeprom conditional loader
`ifndef ECL_MAP_VH
`define ECL_MAP_VH
`define ECL_EE_BYTES 2048
`define ECL_EE_AW 11
`define ECL_OP_CLEAR 8'hb0
`define ECL_OP_COND_HI 4'hb
`define ECL_OP_PAUSE 8'hfe
`define ECL_OP_END 8'hff
`define ECL_OP_IOUPD 8'h80
`define ECL_DATA_MAX 8'h7f
`define ECL_CFG_ADDR 13'h0000
`endif

// ===== hdl/ecl_loader.v
// eeprom conditional loader: upload and download sequencer core
// Operation
// RULE1 - upload stores condition bytes unchanged
// RULE2 - condition and end always execute on download
// RULE3 - active condition 4 bits, zero means unconditional
// RULE4 - nonzero register field wins, else latched pins
// RULE5 - pins reach only conditions one to three
// RULE6 - 0xb1..0xbf tags conditions one to fifteen
// RULE7 - 0xb0 clears all tags
// RULE8 - nonzero condition, tags set: execute only tagged
// RULE9 - tags accumulate until cleared
// RULE10 - storage 2048 bytes, non-data one byte
// RULE11 - data block is n plus four bytes
// RULE12 - software: condition, data, then pause
// RULE13 - software: later setups start with clear
// RULE14 - software: last setup ends with end
// RULE15 - software: write enable before save
// RULE16 - software: condition field then load trigger
// RULE17 - power-up auto download on nonzero pin condition
// RULE18 - spi config register unreachable by sequencer; download here can still write map address zero
// RULE19 - protocol chosen at start-up, held until reset
// RULE20 - data count is value plus one, then address
// RULE21 - checksum mismatch faults, all match completes
// RULE22 - pause keeps upload eeprom pointer
// RULE23 - end on download resets pointer, goes idle
// RULE24 - skipped data block still advanced over
`include "ecl_map.vh"
`default_nettype none
module ecl_loader #(
    parameter AW = `ECL_EE_AW
) (
    // clock and reset
    input wire i_clock,
    input wire i_rst_n,
    // mode pins, sampled once after reset release
    input wire i_load_select_pin_high,
    input wire i_load_select_pin_low,
    input wire i_protocol_select_pin,
    input wire i_addr_select_pin_a,
    input wire i_addr_select_pin_b,
    // control bits
    input wire [3:0] i_cond_field,
    input wire i_write_enable,
    input wire i_save_trigger,
    input wire i_load_trigger,
    // scratchpad read port (byte valid one cycle after address)
    output reg [7:0] o_sp_addr,
    input wire [7:0] i_sp_data,
    // eeprom port (read data valid one cycle after address)
    output reg [AW-1:0] o_ee_addr,
    output reg o_ee_we,
    output reg [7:0] o_ee_wdata,
    input wire [7:0] i_ee_rdata,
    // register map port (read data valid one cycle after address)
    output reg [12:0] o_map_addr,
    output reg o_map_we,
    output reg [7:0] o_map_wdata,
    input wire [7:0] i_map_rdata,
    output reg o_calibrate,
    output reg o_io_update,
    // status
    output wire o_busy,
    output reg o_fault,
    output reg o_complete,
    output reg [3:0] o_active_cond,
    output reg [15:1] o_tag_board,
    output reg o_proto_i2c,
    output reg [1:0] o_i2c_addr_sel
);
////////////////////////////////////////////////////////////////////////////////
localparam S_IDLE = 4'h0;
localparam S_UFET = 4'h1;
localparam S_UOP = 4'h2;
localparam S_UA0 = 4'h3;
localparam S_UA1 = 4'h4;
localparam S_UMAP = 4'h5;
localparam S_UWR = 4'h6;
localparam S_USUM = 4'h7;
localparam S_DFET = 4'h8;
localparam S_DOP = 4'h9;
localparam S_DA0 = 4'ha;
localparam S_DA1 = 4'hb;
localparam S_DDAT = 4'hc;
localparam S_DSUM = 4'hd;
localparam S_WAIT = 4'he;

function is_cond;
    input [7:0] b;
    begin
        is_cond = (b[7:4] == `ECL_OP_COND_HI);
    end
endfunction

reg [3:0] st_reg;
reg [3:0] ret_reg;
reg [1:0] pin_cond_reg;
reg strap_done_reg;
reg [AW-1:0] ee_ptr_reg;
reg [7:0] cnt_reg;
reg [7:0] sum_reg;
reg skip_reg;
reg bad_reg;
reg [15:1] tag_next;
wire [3:0] cond_now;
wire exec_ok;

// register field wins when nonzero; pins only give 1..3 [RULE4] [RULE5] [RULE3]
assign cond_now = (i_cond_field != 4'h0) ? i_cond_field : {2'b00, pin_cond_reg};
// [RULE8] execute if null condition, empty board, or condition tagged
assign exec_ok = (cond_now == 4'h0) || (o_tag_board == 15'h0000) ||
                 o_tag_board[cond_now];
assign o_busy = (st_reg != S_IDLE);

always @* begin
    tag_next = o_tag_board;
    if (i_ee_rdata == `ECL_OP_CLEAR)
        tag_next = 15'h0000; // [RULE7]
    else if (i_ee_rdata[3:0] != 4'h0)
        tag_next[i_ee_rdata[3:0]] = 1'b1; // [RULE6] [RULE9]
end

always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        st_reg <= S_IDLE;
        ret_reg <= S_IDLE;
        pin_cond_reg <= 2'b00;
        strap_done_reg <= 1'b0;
        ee_ptr_reg <= {AW{1'b0}};
        cnt_reg <= 8'h00;
        sum_reg <= 8'h00;
        skip_reg <= 1'b0;
        bad_reg <= 1'b0;
        o_sp_addr <= 8'h00;
        o_ee_addr <= {AW{1'b0}};
        o_ee_we <= 1'b0;
        o_ee_wdata <= 8'h00;
        o_map_addr <= 13'h0000;
        o_map_we <= 1'b0;
        o_map_wdata <= 8'h00;
        o_calibrate <= 1'b0;
        o_io_update <= 1'b0;
        o_fault <= 1'b0;
        o_complete <= 1'b0;
        o_active_cond <= 4'h0;
        o_tag_board <= 15'h0000;
        o_proto_i2c <= 1'b0;
        o_i2c_addr_sel <= 2'b00;
    end else begin
        o_ee_we <= 1'b0;
        o_map_we <= 1'b0;
        o_calibrate <= 1'b0;
        o_io_update <= 1'b0;
        o_active_cond <= cond_now;
        // addresses step the cycle after a strobe, so each byte lands where it was aimed
        if (o_ee_we)
            o_ee_addr <= o_ee_addr + 1'b1; // [RULE10]
        if (o_map_we)
            o_map_addr <= o_map_addr + 1'b1;
        // pins caught once after release; only a reset re-arms this [RULE19]
        if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            pin_cond_reg <= {i_load_select_pin_high, i_load_select_pin_low};
            o_proto_i2c <= i_protocol_select_pin;
            o_i2c_addr_sel <= {i_addr_select_pin_b, i_addr_select_pin_a};
            if (i_load_select_pin_high | i_load_select_pin_low) begin
                st_reg <= S_DFET; // [RULE17]
                o_ee_addr <= {AW{1'b0}};
                o_tag_board <= 15'h0000;
                bad_reg <= 1'b0;
            end
        end else begin
            case (st_reg)
            S_IDLE: begin
                if (i_save_trigger && i_write_enable) begin
                    st_reg <= S_UFET;
                    o_sp_addr <= 8'h00;
                    o_ee_addr <= ee_ptr_reg; // [RULE22]
                end else if (i_load_trigger) begin
                    st_reg <= S_DFET;
                    o_ee_addr <= {AW{1'b0}};
                    o_tag_board <= 15'h0000;
                    bad_reg <= 1'b0;
                    o_fault <= 1'b0;
                    o_complete <= 1'b0;
                end
            end
            // upload: bytes copied verbatim, conditions have no effect [RULE1]
            S_UFET: st_reg <= S_UOP;
            S_UOP: begin
                o_ee_we <= 1'b1;
                o_ee_wdata <= i_sp_data;
                o_sp_addr <= o_sp_addr + 1'b1;
                if (i_sp_data <= `ECL_DATA_MAX) begin
                    cnt_reg <= i_sp_data; // [RULE20]
                    ret_reg <= S_IDLE;
                    sum_reg <= 8'h00;
                    st_reg <= S_UA0;
                end else if (i_sp_data == `ECL_OP_PAUSE) begin
                    ee_ptr_reg <= o_ee_addr + 1'b1; // [RULE22]
                    st_reg <= S_IDLE;
                end else if (i_sp_data == `ECL_OP_END) begin
                    ee_ptr_reg <= {AW{1'b0}};
                    st_reg <= S_IDLE;
                end else
                    st_reg <= S_UFET;
            end
            S_UA0: st_reg <= S_UA1;
            S_UA1: begin
                // address bytes: first holds high bits [RULE11]
                o_ee_we <= 1'b1;
                o_ee_wdata <= i_sp_data;
                o_sp_addr <= o_sp_addr + 1'b1;
                if (ret_reg == S_UA1) begin
                    o_map_addr[7:0] <= i_sp_data;
                    ret_reg <= S_IDLE;
                    st_reg <= S_UMAP;
                end else begin
                    o_map_addr[12:8] <= i_sp_data[4:0];
                    ret_reg <= S_UA1;
                    st_reg <= S_UA0;
                end
            end
            S_UMAP: st_reg <= S_UWR;
            S_UWR: begin
                o_ee_we <= 1'b1;
                o_ee_wdata <= i_map_rdata;
                sum_reg <= sum_reg + i_map_rdata;
                o_map_addr <= o_map_addr + 1'b1;
                cnt_reg <= cnt_reg - 1'b1;
                st_reg <= (cnt_reg == 8'h00) ? S_USUM : S_UMAP;
            end
            S_USUM: begin
                o_ee_we <= 1'b1; // checksum closes the n+4 block [RULE11]
                o_ee_wdata <= sum_reg;
                st_reg <= S_UFET;
            end
            // download
            S_DFET: st_reg <= S_DOP;
            S_DOP: begin
                o_ee_addr <= o_ee_addr + 1'b1;
                st_reg <= S_DFET;
                skip_reg <= !exec_ok;
                if (i_ee_rdata == `ECL_OP_END) begin
                    o_ee_addr <= {AW{1'b0}}; // [RULE23] [RULE2]
                    o_complete <= !bad_reg; // [RULE21]
                    o_fault <= bad_reg;
                    st_reg <= S_IDLE;
                end else if (is_cond(i_ee_rdata))
                    o_tag_board <= tag_next; // [RULE2]
                else if (i_ee_rdata <= `ECL_DATA_MAX) begin
                    cnt_reg <= i_ee_rdata;
                    sum_reg <= 8'h00;
                    st_reg <= S_WAIT;
                    ret_reg <= S_DA0;
                end else if (exec_ok) begin
                    // only 0x80: io update; other non-data bytes except pause treated as calibrate
                    o_io_update <= (i_ee_rdata == `ECL_OP_IOUPD);
                    o_calibrate <= (i_ee_rdata != `ECL_OP_IOUPD) &&
                                   (i_ee_rdata != `ECL_OP_PAUSE);
                end
            end
            S_WAIT: st_reg <= ret_reg;
            S_DA0: begin
                o_map_addr[12:8] <= i_ee_rdata[4:0];
                o_ee_addr <= o_ee_addr + 1'b1;
                st_reg <= S_WAIT;
                ret_reg <= S_DA1;
            end
            S_DA1: begin
                o_map_addr[7:0] <= i_ee_rdata;
                o_ee_addr <= o_ee_addr + 1'b1;
                st_reg <= S_WAIT;
                ret_reg <= S_DDAT;
            end
            S_DDAT: begin
                // skipped blocks still walk every byte, no map writes [RULE24]
                o_map_we <= !skip_reg; // [RULE8]
                o_map_wdata <= i_ee_rdata;
                sum_reg <= sum_reg + i_ee_rdata;
                o_ee_addr <= o_ee_addr + 1'b1;
                cnt_reg <= cnt_reg - 1'b1;
                st_reg <= S_WAIT;
                ret_reg <= (cnt_reg == 8'h00) ? S_DSUM : S_DDAT;
            end
            S_DSUM: begin
                if (i_ee_rdata != sum_reg)
                    bad_reg <= 1'b1; // [RULE21]
                o_ee_addr <= o_ee_addr + 1'b1;
                st_reg <= S_DFET;
            end
            default: st_reg <= S_IDLE;
            endcase
        end
    end
end
// the spi configuration register lives in the port logic; a download block naming
// map address zero is still written, nothing here guards it [RULE18]
endmodule
`default_nettype wire

// ===== bench/ecl_mem_model.sv
// scratchpad, eeprom and register map seen by the loader
`default_nettype none
module ecl_mem_model (
    // clock
    input wire logic i_clock,
    // scratchpad
    input wire logic [7:0] i_sp_addr,
    output logic [7:0] o_sp_data,
    // eeprom
    input wire logic [10:0] i_ee_addr,
    input wire logic i_ee_we,
    input wire logic [7:0] i_ee_wdata,
    output logic [7:0] o_ee_rdata,
    // register map
    input wire logic [12:0] i_map_addr,
    input wire logic i_map_we,
    input wire logic [7:0] i_map_wdata,
    output logic [7:0] o_map_rdata
);
    logic [7:0] sp [256];
    logic [7:0] ee [2048];
    logic [7:0] map [8192];
    // zeroed so an unwritten byte never feeds an unknown checksum
    initial begin
        foreach (sp[i]) sp[i] = 8'h00;
        foreach (ee[i]) ee[i] = 8'h00;
        foreach (map[i]) map[i] = 8'h00;
    end
    assign o_sp_data = sp[i_sp_addr];
    assign o_ee_rdata = ee[i_ee_addr];
    assign o_map_rdata = map[i_map_addr];
    always @(posedge i_clock) begin
        if (i_ee_we) ee[i_ee_addr] <= i_ee_wdata;
        if (i_map_we) map[i_map_addr] <= i_map_wdata;
    end
endmodule
`default_nettype wire

// ===== bench/ecl_loader_sva.sv
// assertion checker for the conditional loader
`default_nettype none
module ecl_loader_sva (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [3:0] i_cond_field,
    input wire logic i_write_enable,
    input wire logic i_save_trigger,
    input wire logic i_load_trigger,
    input wire logic o_ee_we,
    input wire logic o_map_we,
    input wire logic o_busy,
    input wire logic o_fault,
    input wire logic o_complete,
    input wire logic [3:0] o_active_cond,
    input wire logic [15:1] o_tag_board,
    input wire logic o_proto_i2c
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // pins settle on the first edge, so hold is judged from the third
    logic [1:0] armed_reg;
    always_ff @(posedge i_clock or negedge i_rst_n)
        if (!i_rst_n) armed_reg <= 2'b00;
        else armed_reg <= {armed_reg[0], 1'b1};
    ////////////////////////////////////////////////////////////////
    a_field_wins: assert property ((i_cond_field != 4'h0) |=>
        (o_active_cond == $past(i_cond_field))) else $error("condition field ignored");
    a_pin_range: assert property (($past(i_cond_field) == 4'h0) |->
        (o_active_cond <= 4'h3)) else $error("pin condition above three");
    a_save_guard: assert property ((armed_reg[0] && !o_busy && i_save_trigger
        && !i_write_enable && !i_load_trigger) |=> !o_busy)
        else $error("save ran without enable");
    a_load_start: assert property ((armed_reg[0] && !o_busy && i_load_trigger) |=> o_busy)
        else $error("load not taken");
    a_flag_excl: assert property (!(o_complete && o_fault))
        else $error("complete and fault together");
    a_map_pulse: assert property (o_map_we |=> !o_map_we)
        else $error("map write not a pulse");
    a_dir_excl: assert property (o_map_we |-> !o_ee_we)
        else $error("map and eeprom written together");
    a_proto_hold: assert property (armed_reg[1] |-> $stable(o_proto_i2c))
        else $error("protocol changed");
    a_tags_idle: assert property ((!o_busy && !$past(o_busy)) |->
        $stable(o_tag_board)) else $error("tags moved while idle");
endmodule
bind ecl_loader ecl_loader_sva i_sva (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_cond_field(i_cond_field), .i_write_enable(i_write_enable),
    .i_save_trigger(i_save_trigger), .i_load_trigger(i_load_trigger),
    .o_ee_we(o_ee_we), .o_map_we(o_map_we), .o_busy(o_busy), .o_fault(o_fault),
    .o_complete(o_complete), .o_active_cond(o_active_cond),
    .o_tag_board(o_tag_board), .o_proto_i2c(o_proto_i2c));
`default_nettype wire

// ===== bench/tb_ecl_loader.sv
// testbench for the eeprom conditional loader
`default_nettype none
module tb_ecl_loader;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 0, i_rst_n = 0, pin_hi = 0, pin_lo = 0, proto = 1;
    logic [3:0] cond = 0, act;
    logic [1:0] asel;
    logic we = 1, save = 0, load = 0, took, ee_we, map_we, io, busy, fault, done, i2c, cal;
    logic [7:0] sp_a, sp_d, ee_wd, ee_rd, map_wd, map_rd;
    logic [10:0] ee_a;
    logic [12:0] map_a;
    logic [15:1] tags;
    logic [7:0] sq [$];
    int n_mismatch = 0, comparisons = 0, n_io = 0, n_cal = 0, n;
    logic [7:0] ee_exp [19] = '{8'hb1, 8'h01, 8'h00, 8'h10, 8'h12, 8'h34, 8'h46, 8'hfe,
        8'hb0, 8'hb2, 8'hb3, 8'h80, 8'ha0, 8'h00, 8'h00, 8'h20, 8'h56, 8'h56, 8'hff};
    // rows: condition, byte at map 0x10, byte at map 0x20
    logic [19:0] rows [5] = '{20'h01256, 20'h11200, 20'h20056, 20'h30056, 20'h50000};
    always #2.5 i_clock = ~i_clock;
    always @(posedge i_clock) if (io) n_io++;
    always @(posedge i_clock) if (cal) n_cal++;
    ecl_mem_model i_mem (.i_clock(i_clock), .i_sp_addr(sp_a), .o_sp_data(sp_d),
        .i_ee_addr(ee_a), .i_ee_we(ee_we), .i_ee_wdata(ee_wd), .o_ee_rdata(ee_rd),
        .i_map_addr(map_a), .i_map_we(map_we), .i_map_wdata(map_wd), .o_map_rdata(map_rd));
    ecl_loader i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_load_select_pin_high(pin_hi),
        .i_load_select_pin_low(pin_lo), .i_protocol_select_pin(proto),
        .i_addr_select_pin_a(1'b0), .i_addr_select_pin_b(1'b1), .i_cond_field(cond),
        .i_write_enable(we), .i_save_trigger(save), .i_load_trigger(load),
        .o_sp_addr(sp_a), .i_sp_data(sp_d), .o_ee_addr(ee_a), .o_ee_we(ee_we),
        .o_ee_wdata(ee_wd), .i_ee_rdata(ee_rd), .o_map_addr(map_a), .o_map_we(map_we),
        .o_map_wdata(map_wd), .i_map_rdata(map_rd), .o_calibrate(cal), .o_io_update(io),
        .o_busy(busy), .o_fault(fault), .o_complete(done), .o_active_cond(act),
        .o_tag_board(tags), .o_proto_i2c(i2c), .o_i2c_addr_sel(asel));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_idle();
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge i_clock);
            n++;
        end
        if (n >= 5000) n_mismatch++;
    endtask
    task automatic op(input logic is_save);
        @(negedge i_clock);
        save = is_save;
        load = !is_save;
        @(negedge i_clock);
        save = 0;
        load = 0;
        took = busy;
        wait_idle();
        // the closing write strobe lands one edge after busy drops
        @(negedge i_clock);
    endtask
    task automatic reset_dut();
        i_rst_n = 0;
        repeat (8) @(negedge i_clock);
        check({busy, done, tags}, 24'h0);
        i_rst_n = 1;
    endtask
    task automatic fill();
        foreach (sq[i]) i_mem.sp[i] = sq[i];
    endtask
    task automatic clear_map();
        i_mem.map[13'h10] = 8'h00;
        i_mem.map[13'h20] = 8'h00;
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        reset_dut();
        @(negedge i_clock);
        proto = 0;
        i_mem.map[13'h10] = 8'h12;
        i_mem.map[13'h11] = 8'h34;
        i_mem.map[13'h20] = 8'h56;
        sq = '{8'hb1, 8'h01, 8'h00, 8'h10, 8'hfe};
        fill();
        op(1);
        sq = '{8'hb0, 8'hb2, 8'hb3, 8'h80, 8'ha0, 8'h00, 8'h00, 8'h20, 8'hff};
        fill();
        op(1);
        foreach (ee_exp[i]) check(i_mem.ee[i], ee_exp[i]);
        check({i2c, asel}, 3'b110);
        for (int r = 0; r < 5; r++) begin
            cond = rows[r][19:16];
            clear_map();
            n_io = 0;
            n_cal = 0;
            op(0);
            check({took, i_mem.map[13'h10], i_mem.map[13'h20]}, {1'b1, rows[r][15:0]});
            check(24'(n_io), {23'h0, rows[r][7:0] != 8'h00});
            check(24'(n_cal), {23'h0, rows[r][7:0] != 8'h00});
            check({act, done, fault, tags}, {cond, 2'b10, 15'h0006});
        end
        // a corrupted checksum byte must surface as a fault
        i_mem.ee[6] = 8'h47;
        cond = 4'h0;
        op(0);
        check({done, fault}, 2'b01);
        we = 0;
        op(1);
        check(took, 1'b0);
        i_mem.ee[6] = 8'h46;
        pin_hi = 1;
        pin_lo = 1;
        clear_map();
        reset_dut();
        repeat (2) @(negedge i_clock);
        check(busy, 1'b1);
        wait_idle();
        check({act, done, i2c, i_mem.map[13'h10], i_mem.map[13'h20]}, 22'h0e0056);
        complete_run();
    end
endmodule
`default_nettype wire
